// ==== pfds_defs.svh ====
/*
 * Timing counts, field widths and reset values for the print feed and
 * density sequencer. Assumes a 100 MHz system clock.
 */
`ifndef PFDS_DEFS_SVH
`define PFDS_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PFDS_CLK_MHZ         100
`define PFDS_MOTOR_STAGGER_MS 200
`define PFDS_MOTOR_STAGGER_CYC (`PFDS_MOTOR_STAGGER_MS * 1000 * `PFDS_CLK_MHZ)
`define PFDS_TH_PERIOD_MIN   30
`define PFDS_TH_PERIOD_CYC   (64'(`PFDS_TH_PERIOD_MIN) * 60 * 1000 * 1000 * `PFDS_CLK_MHZ)
`define PFDS_REG_HOLD_CYC    100000
`define PFDS_DRUM_SYNC_CYC   50000
`define PFDS_PATCH_CYC       1000

// ----------------------------------------------------------------------
// Counts and widths
// ----------------------------------------------------------------------
`define PFDS_PRINT_THRESH    100
`define PFDS_PATCH_COUNT     8
`define PFDS_DENS_W          8
`define PFDS_LUT_DEPTH       16
`define PFDS_LUT_AW          4
`define PFDS_LED_LEVEL       8'hC0
`define PFDS_DEFAULT_BIAS    8'h80
`define PFDS_BLOCKED_LEVEL   8'h08

`endif

// ==== pfds_pkg.sv ====
/*
 * Types shared by the print feed and density sequencer files.
 * Assumes pfds_defs.svh is on the include path.
 */
`include "pfds_defs.svh"

package pfds_pkg;

    typedef enum logic [6:0] {
        FEED_IDLE   = 7'b0000001,
        FEED_MAIN   = 7'b0000010,
        FEED_PICK   = 7'b0000100,
        FEED_REGW   = 7'b0001000,
        FEED_EDGE   = 7'b0010000,
        FEED_SYNC   = 7'b0100000,
        FEED_RUN    = 7'b1000000
    } pfds_feed_t;

    typedef enum logic [3:0] {
        CAL_IDLE    = 4'b0001,
        CAL_PATCH   = 4'b0010,
        CAL_SETTLE  = 4'b0100,
        CAL_DONE    = 4'b1000
    } pfds_cal_t;

    typedef struct packed {
        logic       main_motor;
        logic       drum_motor;
        logic       pickup_motor;
        logic       cassette_pickup_solenoid;
        logic       registration_clutch_drive_n;
    } pfds_mech_t;

    typedef struct packed {
        logic       density_mode_select_n;
        logic       density_sense_enable_n;
        logic [7:0] sensor_led_power_level_n;
    } pfds_sense_t;

    typedef struct packed {
        logic [7:0] primary_charge;
        logic [7:0] transfer_bias;
        logic [7:0] attraction_bias;
        logic [7:0] discharge_ac_bias;
        logic       separation_discharge_on;
    } pfds_hv_t;

endpackage

// ==== pfds_halftone_lut.sv ====
/*
 * Halftone correction table: remaps requested laser levels.
 * Assumes the sequencer writes it only during a calibration run.
 */
`timescale 1ns/1ps
`include "pfds_defs.svh"

module pfds_halftone_lut #(
    parameter int DEPTH = `PFDS_LUT_DEPTH,
    parameter int AW    = `PFDS_LUT_AW,
    parameter int DW    = `PFDS_DENS_W
) (
    input  wire logic          clk_i,
    input  wire logic          srst_i,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_idx_i,
    input  wire logic [DW-1:0] wr_val_i,
    input  wire logic [DW-1:0] level_i,
    output logic      [DW-1:0] laser_o
);
    import pfds_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] tab;
        logic [DW-1:0]            out;
    } pfds_lut_state_t;

    pfds_lut_state_t s_q;
    pfds_lut_state_t s_d;
    logic [AW-1:0]   rd_idx;

    // Upper bits of the level pick the entry
    assign rd_idx = level_i[DW-1 -: AW];

    always_comb
    begin
        s_d = s_q;
        if (wr_en_i)
        begin
            s_d.tab[wr_idx_i] = wr_val_i;
        end
        s_d.out = s_q.tab[rd_idx];
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                s_q.tab[i] <= DW'((i * 256) / DEPTH);
            end
            s_q.out <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign laser_o = s_q.out;

    chk_lut_write_used: assert property (@(posedge clk_i) disable iff (srst_i)
        wr_en_i && !$past(srst_i) |=> s_q.tab[$past(wr_idx_i)] == $past(wr_val_i))
        else $error("table write not stored");
endmodule

// ==== pfds_sequencer.sv ====
/*
 * Print feed and density sequencer: calibration scheduling, density
 * patch sensing, halftone table upkeep and pickup/feed timing.
 * Assumes all inputs are synchronous to clk_i and already debounced.
 */
`timescale 1ns/1ps
`include "pfds_defs.svh"

module pfds_sequencer
    import pfds_pkg::*;
#(
    parameter int          PRINT_THRESH = `PFDS_PRINT_THRESH,
    parameter int unsigned STAGGER_CYC  = `PFDS_MOTOR_STAGGER_CYC,
    parameter longint unsigned TH_PERIOD_CYC = `PFDS_TH_PERIOD_CYC,
    parameter int unsigned REG_HOLD_CYC = `PFDS_REG_HOLD_CYC,
    parameter int unsigned DRUM_SYNC_CYC = `PFDS_DRUM_SYNC_CYC,
    parameter int unsigned PATCH_CYC    = `PFDS_PATCH_CYC
) (
    input  wire logic                    clk_i,
    input  wire logic                    srst_i,
    input  wire logic                    print_request_n_i,
    input  wire logic                    scanner_ready_i,
    input  wire logic                    env_abrupt_change_i,
    input  wire logic                    toner_installed_i,
    input  wire logic                    drum_cartridge_new_i,
    input  wire logic                    th_change_i,
    input  wire logic [7:0]              th_reading_i,
    input  wire logic                    sep_override_en_i,
    input  wire logic                    sep_override_val_i,
    input  wire logic [7:0]              toner_density_value_i,
    input  wire logic                    sensor_blocked_i,
    input  wire logic [7:0]              halftone_level_i,
    input  wire logic                    cassette_empty_flag_i,
    input  wire logic                    registration_paper_flag_n_i,
    input  wire logic                    leading_edge_paper_flag_i,
    input  wire logic                    transfer_drum_top_sensor_i,
    input  wire logic                    print_done_i,
    output logic                         th_measure_o,
    output logic                         calibrating_o,
    output logic                         feed_busy_o,
    output pfds_pkg::pfds_mech_t         mech_o,
    output pfds_pkg::pfds_sense_t        sense_o,
    output pfds_pkg::pfds_hv_t           hv_o,
    output logic [3:0][7:0]              dev_bias_o,
    output logic [7:0]                   laser_level_o
);
    import pfds_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        pfds_feed_t       feed;
        pfds_cal_t        cal;
        logic [31:0]      tmr;
        logic [39:0]      th_tmr;
        logic [7:0]       prints;
        logic             cal_pend;
        logic [3:0]       patch;
        logic [31:0]      ptmr;
        logic [3:0][7:0]  bias;
        logic             lut_we;
        logic [3:0]       lut_idx;
        logic [7:0]       lut_val;
        logic             th_meas;
        pfds_mech_t       mech;
        pfds_sense_t      sense;
        pfds_hv_t         hv;
        logic             drum_mark;
        logic             cal_busy;
        logic             feed_busy;
    } pfds_state_t;

    pfds_state_t s_q;
    pfds_state_t s_d;
    logic        cal_trigger;
    logic        drum_rise;

    // Add half a raw reading to a fixed base, saturating; used for each 8-bit high voltage level
    function automatic logic [7:0] hv_scale(input logic [7:0] r, input logic [7:0] base);
        logic [8:0] sum;
        sum = {1'b0, base} + {2'b00, r[7:1]};
        hv_scale = sum[8] ? 8'hFF : sum[7:0];
    endfunction

    // Fold a patch reading into a correction entry; any result outside 8 bits gives 0
    function automatic logic [7:0] lut_entry(input logic [3:0] idx, input logic [7:0] dens);
        logic [8:0] v;
        v = {1'b0, idx, 4'h0} + {1'b0, 8'h80} - {1'b0, dens};
        lut_entry = v[8] ? 8'h00 : v[7:0];
    endfunction

    assign cal_trigger = env_abrupt_change_i || toner_installed_i
                       || drum_cartridge_new_i
                       || (s_q.prints >= 8'(PRINT_THRESH));

    assign drum_rise = transfer_drum_top_sensor_i && !s_q.drum_mark;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.lut_we  = 1'b0;
        s_d.th_meas = 1'b0;
        s_d.drum_mark = transfer_drum_top_sensor_i;

        // Periodic environment sampling runs regardless of printing
        if (s_q.th_tmr == 40'(TH_PERIOD_CYC - 1))
        begin
            s_d.th_tmr  = '0;
            s_d.th_meas = 1'b1;
        end
        else
        begin
            s_d.th_tmr = s_q.th_tmr + 40'd1;
        end

        if (th_change_i)
        begin
            s_d.hv.primary_charge    = hv_scale(th_reading_i, 8'h40);
            s_d.hv.transfer_bias     = hv_scale(th_reading_i, 8'h30);
            s_d.hv.attraction_bias   = hv_scale(th_reading_i, 8'h20);
            s_d.hv.discharge_ac_bias = hv_scale(th_reading_i, 8'h50);
            s_d.hv.separation_discharge_on = th_reading_i[7];
        end
        if (sep_override_en_i)
        begin
            s_d.hv.separation_discharge_on = sep_override_val_i;
        end

        if (print_done_i && s_q.prints != 8'hFF)
        begin
            s_d.prints = s_q.prints + 8'd1;
        end
        if (cal_trigger)
        begin
            s_d.cal_pend = 1'b1;
        end

        // ------------------------------------------------------------
        // Calibration
        // ------------------------------------------------------------
        unique case (s_q.cal)
            CAL_IDLE:
            begin
                // Only start between prints so the drum is free
                if (s_q.cal_pend && s_q.feed == FEED_IDLE)
                begin
                    s_d.cal      = CAL_PATCH;
                    // Count clears here, so only outside triggers stay pending
                    s_d.cal_pend = env_abrupt_change_i || toner_installed_i
                                 || drum_cartridge_new_i;
                    s_d.prints   = '0;
                    s_d.patch    = '0;
                    s_d.ptmr     = '0;
                    s_d.th_meas  = 1'b1;
                end
            end
            CAL_PATCH:
            begin
                // Last patch of the series is black, the rest colour
                s_d.sense.density_mode_select_n =
                    (s_q.patch != 4'(`PFDS_PATCH_COUNT - 1));
                s_d.sense.density_sense_enable_n   = 1'b0;
                s_d.sense.sensor_led_power_level_n = ~`PFDS_LED_LEVEL;
                s_d.ptmr = s_q.ptmr + 32'd1;
                if (s_q.ptmr == PATCH_CYC - 1)
                begin
                    s_d.ptmr   = '0;
                    s_d.lut_we = 1'b1;
                    s_d.lut_idx = s_q.patch;
                    s_d.lut_val = sensor_blocked_i ? {s_q.patch, 4'h0}
                                : lut_entry(s_q.patch, toner_density_value_i);
                    if (s_q.patch < 4'd4)
                    begin
                        s_d.bias[s_q.patch[1:0]] = sensor_blocked_i ? `PFDS_DEFAULT_BIAS
                                                 : ~toner_density_value_i;
                    end
                    if (s_q.patch == 4'(`PFDS_PATCH_COUNT - 1))
                    begin
                        s_d.cal = CAL_SETTLE;
                    end
                    else
                    begin
                        s_d.patch = s_q.patch + 4'd1;
                    end
                end
            end
            CAL_SETTLE:
            begin
                s_d.sense.density_sense_enable_n   = 1'b1;
                s_d.sense.sensor_led_power_level_n = 8'hFF;
                s_d.cal = CAL_DONE;
            end
            CAL_DONE:
            begin
                s_d.cal = CAL_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // Pickup and feed
        // ------------------------------------------------------------
        s_d.tmr = s_q.tmr + 32'd1;
        unique case (s_q.feed)
            FEED_IDLE:
            begin
                s_d.tmr = '0;
                if (!print_request_n_i && scanner_ready_i && s_q.cal == CAL_IDLE
                    && !s_q.cal_pend && !cassette_empty_flag_i)
                begin
                    s_d.feed = FEED_MAIN;
                    s_d.mech.main_motor = 1'b1;
                end
            end
            FEED_MAIN:
            begin
                if (s_q.tmr == STAGGER_CYC - 1)
                begin
                    s_d.feed = FEED_PICK;
                    s_d.tmr  = '0;
                    s_d.mech.drum_motor   = 1'b1;
                    s_d.mech.pickup_motor = 1'b1;
                    s_d.mech.cassette_pickup_solenoid = 1'b1;
                end
            end
            FEED_PICK:
            begin
                s_d.tmr = '0;
                if (!registration_paper_flag_n_i)
                begin
                    s_d.feed = FEED_REGW;
                    s_d.mech.cassette_pickup_solenoid = 1'b0;
                end
            end
            FEED_REGW:
            begin
                // Clutch stays released so the sheet buckles and deskews
                if (s_q.tmr == REG_HOLD_CYC - 1)
                begin
                    s_d.feed = FEED_EDGE;
                    s_d.mech.registration_clutch_drive_n = 1'b0;
                end
            end
            FEED_EDGE:
            begin
                s_d.tmr = '0;
                if (leading_edge_paper_flag_i)
                begin
                    s_d.feed = FEED_SYNC;
                    s_d.tmr  = 32'h8000_0000;
                    s_d.mech.pickup_motor = 1'b0;
                end
            end
            FEED_SYNC:
            begin
                // Bit 31 set: still waiting for the drum mark
                if (s_q.tmr[31])
                begin
                    s_d.tmr = drum_rise ? 32'd0 : s_q.tmr;
                end
                else if (s_q.tmr == DRUM_SYNC_CYC - 1)
                begin
                    s_d.feed = FEED_RUN;
                    s_d.mech.pickup_motor = 1'b1;
                end
            end
            FEED_RUN:
            begin
                if (print_done_i)
                begin
                    s_d.feed = FEED_IDLE;
                    s_d.mech = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
                end
            end
        endcase
        s_d.cal_busy  = (s_d.cal != CAL_IDLE);
        s_d.feed_busy = (s_d.feed != FEED_IDLE);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s_q.feed     <= FEED_IDLE;
            s_q.cal      <= CAL_IDLE;
            s_q.tmr      <= '0;
            s_q.th_tmr   <= '0;
            s_q.prints   <= '0;
            s_q.cal_pend <= 1'b1;
            s_q.patch    <= '0;
            s_q.ptmr     <= '0;
            s_q.bias     <= {4{`PFDS_DEFAULT_BIAS}};
            s_q.lut_we   <= 1'b0;
            s_q.lut_idx  <= '0;
            s_q.lut_val  <= '0;
            s_q.th_meas  <= 1'b0;
            s_q.mech     <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
            s_q.sense    <= '{1'b1, 1'b1, 8'hFF};
            s_q.hv       <= '0;
            s_q.drum_mark <= 1'b0;
            s_q.cal_busy  <= 1'b0;
            s_q.feed_busy <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    pfds_halftone_lut u_lut (
        .clk_i    (clk_i),
        .srst_i   (srst_i),
        .wr_en_i  (s_q.lut_we),
        .wr_idx_i (s_q.lut_idx),
        .wr_val_i (s_q.lut_val),
        .level_i  (halftone_level_i),
        .laser_o  (laser_level_o)
    );

    assign th_measure_o  = s_q.th_meas;
    assign calibrating_o = s_q.cal_busy;
    assign feed_busy_o   = s_q.feed_busy;
    assign mech_o        = s_q.mech;
    assign sense_o       = s_q.sense;
    assign hv_o          = s_q.hv;
    assign dev_bias_o    = s_q.bias;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence seq_start;
        s_q.feed == FEED_IDLE && s_d.feed == FEED_MAIN;
    endsequence

    chk_start_gate: assert property (@(posedge clk_i) disable iff (srst_i)
        seq_start |-> !print_request_n_i && scanner_ready_i)
        else $error("print started without request and ready");
    chk_main_first: assert property (@(posedge clk_i) disable iff (srst_i)
        seq_start |=> mech_o.main_motor && !mech_o.drum_motor && !mech_o.pickup_motor)
        else $error("main motor not first");
    chk_drum_with_pick: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(mech_o.drum_motor) |-> mech_o.pickup_motor && mech_o.cassette_pickup_solenoid)
        else $error("drum and pickup not together");
    chk_clutch_hold: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.feed == FEED_REGW |-> mech_o.registration_clutch_drive_n)
        else $error("clutch engaged during hold");
    chk_edge_stop: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.feed == FEED_EDGE && leading_edge_paper_flag_i |=> !mech_o.pickup_motor)
        else $error("pickup not stopped at edge");
    chk_led_on_cal: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.cal == CAL_PATCH && $past(s_q.cal) == CAL_PATCH |-> !sense_o.density_sense_enable_n)
        else $error("LED dark during patch");
    chk_sep_override: assert property (@(posedge clk_i) disable iff (srst_i)
        sep_override_en_i |=> hv_o.separation_discharge_on == $past(sep_override_val_i))
        else $error("override ignored");
    chk_cal_clears: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.cal == CAL_IDLE && s_d.cal == CAL_PATCH |=> s_q.prints == '0)
        else $error("print count not cleared");
endmodule

// ==== pfds_paper_model.sv ====
/* Paper path model: the feed sensors answer the sequencer's mech outputs.
   Assumes mech_i comes from the sequencer on the same clock. */
`timescale 1ns/1ps
module pfds_paper_model
    import pfds_pkg::*;
(
    input  wire logic            clk_i,
    input  pfds_pkg::pfds_mech_t mech_i,
    output logic                 reg_n_o,
    output logic                 edge_o,
    output logic                 top_o,
    output logic                 done_o
);
    logic [2:0] ph_q  = 3'h0;
    logic [7:0] cnt_q = 8'h00;
    logic [5:0] rot_q = 6'h00;
    logic       top_q = 1'b0;
    wire        adv   = (ph_q == 3'h0) ? mech_i.cassette_pickup_solenoid && cnt_q > 8'h08 :
                        (ph_q == 3'h1) ? !mech_i.registration_clutch_drive_n && cnt_q > 8'h08 :
                        (ph_q == 3'h2) ? !mech_i.pickup_motor :
                        (ph_q == 3'h3) ? mech_i.pickup_motor && cnt_q > 8'h1E : 1'b1;
    always @(posedge clk_i)
    begin
        cnt_q <= adv ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hFF};
        ph_q  <= adv ? ((ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1) : ph_q;
        rot_q <= mech_i.drum_motor ? rot_q + 6'h01 : 6'h00;
        // Drum mark only while the drum turns
        top_q <= mech_i.drum_motor && rot_q == 6'h3F;
    end
    assign reg_n_o = !(ph_q inside {3'h1, 3'h2, 3'h3});
    assign edge_o  = ph_q inside {3'h2, 3'h3};
    assign top_o   = top_q;
    assign done_o  = ph_q == 3'h4;
endmodule

// ==== tb_pfds_sequencer.sv ====
/* Self-checking bench for pfds_sequencer with shortened counts.
   Assumes pfds_defs.svh on the include path and pfds_paper_model. */
`timescale 1ns/1ps
module tb_pfds_sequencer;
    import pfds_pkg::*;
    localparam int STG = 100;
    localparam int TH  = 500;
    localparam int RH  = 20;
    localparam int DS  = 20;
    localparam int PC  = 10;
    localparam int PT  = 2;
    logic            clk_i = 1'b0;
    logic            srst_i = 1'b1;
    logic            req_n = 1'b1, rdy = 1'b0, env = 1'b0, ton = 1'b0, drn = 1'b0;
    logic            thc = 1'b0, ov_en = 1'b0, ov_v = 1'b0, blk = 1'b0, emp = 1'b0;
    logic [7:0]      thr = 8'h00, dens = 8'h00, lvl = 8'h00, lv = 8'h00;
    logic            reg_n, edg, top, done, thm, cal, busy;
    pfds_mech_t      mech;
    pfds_sense_t     sns;
    pfds_hv_t        hv;
    logic [3:0][7:0] bias;
    logic [7:0]      laser;
    int              miscompares = 0, check_count = 0, seed = 60, cyc = 0, n = 0;
    pfds_sequencer #(
        .PRINT_THRESH(PT), .STAGGER_CYC(STG), .TH_PERIOD_CYC(TH),
        .REG_HOLD_CYC(RH), .DRUM_SYNC_CYC(DS), .PATCH_CYC(PC)
    ) dut_u (
        .clk_i(clk_i), .srst_i(srst_i), .print_request_n_i(req_n),
        .scanner_ready_i(rdy), .env_abrupt_change_i(env), .toner_installed_i(ton),
        .drum_cartridge_new_i(drn), .th_change_i(thc), .th_reading_i(thr),
        .sep_override_en_i(ov_en), .sep_override_val_i(ov_v),
        .toner_density_value_i(dens), .sensor_blocked_i(blk),
        .halftone_level_i(lvl), .cassette_empty_flag_i(emp),
        .registration_paper_flag_n_i(reg_n), .leading_edge_paper_flag_i(edg),
        .transfer_drum_top_sensor_i(top), .print_done_i(done),
        .th_measure_o(thm), .calibrating_o(cal), .feed_busy_o(busy), .mech_o(mech),
        .sense_o(sns), .hv_o(hv), .dev_bias_o(bias), .laser_level_o(laser)
    );
    pfds_paper_model pm_u (.clk_i(clk_i), .mech_i(mech), .reg_n_o(reg_n), .edge_o(edg),
        .top_o(top), .done_o(done));
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    // Fresh values each cycle so a stale density sample cannot hide
    always @(posedge clk_i)
    begin
        dens <= 8'($random(seed));
        lvl  <= 8'($random(seed));
        thr  <= 8'($random(seed));
        cyc  <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask
    function automatic logic pick(input int s);
        logic [12:0] v;
        v = {!mech.main_motor, !mech.cassette_pickup_solenoid, !sns.density_sense_enable_n,
             edg, top, thm, !cal, cal, mech.pickup_motor, !mech.pickup_motor,
             !mech.registration_clutch_drive_n, mech.drum_motor, mech.main_motor};
        return v[s];
    endfunction
    task automatic cy(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    // Bounded wait; n holds the edges it took
    task automatic wt(input int s, input int lim);
        n = 0;
        while (pick(s) !== 1'b1 && n < lim)
        begin
            cy(1);
            n++;
        end
        if (pick(s) !== 1'b1)
            chk(16'(s), 16'hFFFF, 16'hFFFF);
    endtask
    task automatic print_one();
        req_n <= 1'b0;
        wt(0, 5);
        req_n <= 1'b1;
        wt(1, STG + 5);
        chk(16'(n), 16'(STG), 16'(STG));
        chk(16'({mech.pickup_motor, mech.cassette_pickup_solenoid}), 16'h3, 16'h3);
        wt(11, 50);
        wt(2, RH + 5);
        chk(16'(n), 16'(RH - 1), 16'(RH + 1));
        wt(9, 50);
        wt(3, 3);
        wt(8, 100);
        wt(4, DS + 5);
        chk(16'(n), 16'(DS), 16'(DS + 2));
        wt(12, 100);
        chk(16'(mech), 16'h01, 16'h01);
        $display("test print done");
    endtask
    task automatic end_sim();
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        #1;
        chk(16'(mech), 16'h01, 16'h01);
        chk(16'({sns.density_sense_enable_n, sns.sensor_led_power_level_n}), 16'h1FF, 16'h1FF);
        wt(5, 5);
        wt(10, 5);
        cy(5);
        chk(16'({sns.density_mode_select_n, sns.sensor_led_power_level_n}), 16'h13F, 16'h13F);
        cy(PC * 7);
        chk(16'(sns.density_mode_select_n), 16'h0, 16'h0);
        wt(6, 50);
        $display("test power_on_cal done");
        for (int i = 0; i < 3; i++)
        begin
            blk <= (i == 1);
            {env, ton, drn} <= 3'(4 >> i);
            cy(1);
            {env, ton, drn} <= 3'h0;
            wt(5, 5);
            chk(16'(thm), 16'h1, 16'h1);
            wt(6, 150);
            if (i == 1)
            begin
                chk({bias[0], bias[3]}, 16'h8080, 16'h8080);
                // Blocked patches rewrite the linear default entries, so the level's upper nibble comes back
                repeat (4)
                begin
                    lv = lvl;
                    cy(1);
                    chk(16'(laser), {8'h00, lv[7:4], 4'h0}, {8'h00, lv[7:4], 4'h0});
                end
            end
        end
        $display("test triggers done");
        {emp, rdy, req_n} <= 3'b110;
        cy(30);
        chk(16'(mech.main_motor), 16'h0, 16'h0);
        {emp, rdy} <= 2'b00;
        cy(30);
        chk(16'(mech.main_motor), 16'h0, 16'h0);
        {rdy, req_n} <= 2'b11;
        cy(1);
        for (int p = 0; p < PT; p++)
        begin
            print_one();
            cy(6);
            chk(16'(cal), 16'(p == PT - 1), 16'(p == PT - 1));
        end
        wt(6, 150);
        thc <= 1'b1;
        cy(1);
        thc <= 1'b0;
        chk(16'(hv.primary_charge), 16'h01, 16'hFF);
        for (int v = 0; v < 2; v++)
        begin
            {ov_en, ov_v} <= {1'b1, v[0]};
            cy(3);
            chk(16'(hv.separation_discharge_on), 16'(v), 16'(v));
        end
        $display("test override done");
        wt(7, TH + 10);
        cy(1);
        wt(7, TH + 10);
        chk(16'(n), 16'(TH - 2), 16'(TH));
        $display("test th_period done");
        end_sim();
    end
endmodule
